/* File: rtl/wss_pkg.sv */
package wss_pkg;
    // Register byte offsets
    localparam logic [7:0] WSS_CTRL_OFS = 8'h00;
    localparam logic [7:0] WSS_SEGSEL_OFS = 8'h04;
    localparam logic [7:0] WSS_STATUS_OFS = 8'h08;
    localparam logic [7:0] WSS_MARK_OFS = 8'h0C;
    localparam logic [7:0] WSS_ENTRY_BASE = 8'h10;
    localparam logic [7:0] WSS_FUNC_OFS = 8'h20;
    // Control field positions
    localparam int WSS_RUN_BIT = 0;
    localparam int WSS_ADV_TRIG_BIT = 1;
    localparam int WSS_LEVEL_BIT = 2;
    localparam int WSS_AT_ONCE_BIT = 3;
    localparam int WSS_LEN_LSB = 4;
    // Mark register fields
    localparam int WSS_MARK_SET_BIT = 31;
    localparam int WSS_MARK_CLR_BIT = 30;
    localparam int WSS_MARK_TRACE_LSB = 16;
    // Limits and reset values
    localparam logic [2:0] WSS_LEN_MIN = 3'h2;
    localparam logic [2:0] WSS_LEN_MAX = 3'h4;
    localparam logic [15:0] WSS_COUNT_RST = 16'h0001;
    localparam int WSS_NSEG = 4;
    localparam int WSS_NTRACE = 4;
    localparam int WSS_NPOINT = 16;
    // Output function selection
    typedef enum logic [1:0] {
        WSS_FN_OTHER = 2'b00,
        WSS_FN_USER = 2'b01,
        WSS_FN_SEQ = 2'b10
    } wss_fn_t;
    // AXI response codes
    localparam logic [1:0] WSS_RESP_OK = 2'h0;
    localparam logic [1:0] WSS_RESP_ERR = 2'h2;
endpackage : wss_pkg

/* File: rtl/wss_fifo.sv */
`timescale 1ns/100ps
// Small synchronous FIFO with valid/ready on both sides
module wss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    // Pointers and fill count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // Storage
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : wss_fifo

/* File: rtl/wss_top.sv */
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Function
// - Auto mode advances after repeat count done
// - Trigger mode waits trigger after count
// - Four segment slots, index zero first
// - Per-segment repeat count, default one
// - Count and segment share one index
// - Count zero repeats segment forever
// - Length two to four, limits index
// - List used only in sequence function
// - Trigger steps only in advance_on_trigger mode
// - Edge sensitivity fires on rising edge
// - Level sensitivity fires while held high
// - Synchronous switch waits for segment end
// - Switch_at_once switch happens at once
// - Clear-all command clears one trace's markers
// - Set-marker command sets one point
// - User waveform only in user function
module wss_top
    import wss_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_in,
    input wire logic seg_end,
    output logic [7:0] wave_sel,
    output logic wave_sel_valid,
    input wire logic wave_sel_ready,
    output logic [wss_pkg::WSS_NPOINT-1:0] marker_bits [wss_pkg::WSS_NTRACE]
);
    import wss_pkg::*;
    // Configuration registers
    logic [31:0] ctrl_q;
    wss_fn_t fn_q;
    logic [7:0] user_wave_q;
    logic [7:0] seg_wave_q [WSS_NSEG];
    logic [15:0] seg_count_q [WSS_NSEG];
    logic [WSS_NPOINT-1:0] mark_q [WSS_NTRACE];
    // Sequencer state
    logic [1:0] idx_q;
    logic [15:0] rep_q;
    logic wait_q;
    logic pend_q;
    logic trig_prev_q;
    logic [7:0] last_sel_q;
    // Bus state
    logic aw_held_q, w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [1:0] bresp_q;
    logic bvalid_q, rvalid_q;
    // Control decode
    wire run = ctrl_q[WSS_RUN_BIT];
    wire adv_on_trigger = ctrl_q[WSS_ADV_TRIG_BIT];
    wire level_sense = ctrl_q[WSS_LEVEL_BIT];
    wire switch_at_once = ctrl_q[WSS_AT_ONCE_BIT];
    wire [2:0] seq_len = ctrl_q[WSS_LEN_LSB +: 3];
    wire [1:0] last_idx = 2'(seq_len - 3'h1);
    // Trigger event
    wire trig_evt = level_sense ? trig_in : (trig_in && !trig_prev_q);
    wire seq_mode = (fn_q == WSS_FN_SEQ);
    wire [15:0] cur_count = seg_count_q[idx_q];
    wire count_done = seg_end && (cur_count != 16'h0000) && (rep_q == 16'h0001);
    wire trig_ok = adv_on_trigger && trig_evt;
    wire go_auto = !adv_on_trigger && count_done;
    wire go_trig_wait = wait_q && trig_ok;
    wire go_at_once = trig_ok && switch_at_once && !wait_q;
    wire go_sync = pend_q && seg_end && !switch_at_once;
    wire step = run && seq_mode && (go_auto || go_trig_wait || go_at_once || go_sync);
    wire [1:0] nidx = (idx_q == last_idx) ? 2'h0 : idx_q + 2'h1;
    // Output selection
    wire [7:0] sel_now = seq_mode ? seg_wave_q[idx_q] : user_wave_q;
    wire sel_live = run && (seq_mode || fn_q == WSS_FN_USER);
    wire sel_push = sel_live && (sel_now != last_sel_q);
    logic fifo_ready;
    // Sequencer process
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_q <= 2'h0;
            rep_q <= WSS_COUNT_RST;
            wait_q <= 1'b0;
            pend_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_in;
            if (!run || !seq_mode) begin
                // Idle: restart at index zero
                idx_q <= 2'h0;
                rep_q <= seg_count_q[0];
                wait_q <= 1'b0;
                pend_q <= 1'b0;
            end else if (step) begin
                idx_q <= nidx;
                rep_q <= seg_count_q[nidx];
                wait_q <= 1'b0;
                pend_q <= 1'b0;
            end else begin
                if (seg_end && rep_q != 16'h0001 && cur_count != 16'h0000) begin
                    rep_q <= rep_q - 16'h0001;
                end
                if (count_done && adv_on_trigger) begin
                    wait_q <= 1'b1;
                end
                if (trig_ok && !switch_at_once && !wait_q) begin
                    pend_q <= 1'b1;
                end
            end
        end
    end
    // Selection change tracking; stalls while FIFO is full
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_sel_q <= 8'hFF;
        end else if (!sel_live) begin
            last_sel_q <= 8'hFF;
        end else if (sel_push && fifo_ready) begin
            last_sel_q <= sel_now;
        end
    end
    // Selected waveform to playback path
    wss_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(sel_push),
        .in_ready(fifo_ready),
        .in_data(sel_now),
        .out_valid(wave_sel_valid),
        .out_ready(wave_sel_ready),
        .out_data(wave_sel)
    );
    // AXI write path
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire [7:0] wa = aw_addr_q;
    wire wa_entry = (wa[7:4] == WSS_ENTRY_BASE[7:4]);
    wire [1:0] wa_idx = wa[3:2];
    wire wa_idx_ok = ({1'b0, wa_idx} < seq_len);
    wire [2:0] new_len = w_data_q[WSS_LEN_LSB +: 3];
    wire len_ok = (new_len >= WSS_LEN_MIN) && (new_len <= WSS_LEN_MAX);
    wire wa_hit = (wa == WSS_CTRL_OFS && len_ok) || wa == WSS_SEGSEL_OFS
        || wa == WSS_MARK_OFS || wa == WSS_FUNC_OFS || (wa_entry && wa_idx_ok);
    wire [1:0] mk_trace = w_data_q[WSS_MARK_TRACE_LSB +: 2];
    wire [3:0] mk_point = w_data_q[3:0];
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    // Write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= WSS_RESP_OK;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wa_hit ? WSS_RESP_OK : WSS_RESP_ERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end
    // Register updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= {25'h0, WSS_LEN_MIN, 4'h0};
            fn_q <= WSS_FN_OTHER;
            user_wave_q <= 8'h00;
            for (int i = 0; i < WSS_NSEG; i++) begin
                seg_wave_q[i] <= 8'(i);
                seg_count_q[i] <= WSS_COUNT_RST;
            end
            for (int t = 0; t < WSS_NTRACE; t++) begin
                mark_q[t] <= '0;
            end
        end else if (do_write && wa_hit && w_strb_q[0]) begin
            if (wa == WSS_CTRL_OFS) begin
                ctrl_q <= {25'h0, new_len, w_data_q[3:0]};
            end else if (wa == WSS_FUNC_OFS) begin
                fn_q <= wss_fn_t'(w_data_q[1:0]);
            end else if (wa == WSS_SEGSEL_OFS) begin
                user_wave_q <= w_data_q[7:0];
            end else if (wa == WSS_MARK_OFS) begin
                if (w_data_q[WSS_MARK_CLR_BIT]) begin
                    mark_q[mk_trace] <= '0;
                end else if (w_data_q[WSS_MARK_SET_BIT]) begin
                    mark_q[mk_trace][mk_point] <= 1'b1;
                end
            end else if (wa_entry) begin
                seg_wave_q[wa_idx] <= w_data_q[7:0];
                seg_count_q[wa_idx] <= w_data_q[31:16];
            end
        end
    end
    // Marker outputs
    genvar g;
    generate
        for (g = 0; g < WSS_NTRACE; g++) begin : g_mark
            assign marker_bits[g] = mark_q[g];
        end
    endgenerate
    // AXI read path
    wire [7:0] ra = s_axi_araddr;
    wire ra_entry = (ra[7:4] == WSS_ENTRY_BASE[7:4]);
    wire [31:0] rd_mux = (ra == WSS_CTRL_OFS) ? ctrl_q :
        (ra == WSS_SEGSEL_OFS) ? {24'h0, user_wave_q} :
        (ra == WSS_STATUS_OFS) ? {rep_q, 12'h0, pend_q, wait_q, idx_q} :
        (ra == WSS_FUNC_OFS) ? {30'h0, fn_q} :
        ra_entry ? {seg_count_q[ra[3:2]], 8'h00, seg_wave_q[ra[3:2]]} : 32'h0;
    wire ra_hit = ra == WSS_CTRL_OFS || ra == WSS_SEGSEL_OFS || ra == WSS_STATUS_OFS
        || ra == WSS_FUNC_OFS || ra_entry;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= WSS_RESP_OK;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= ra_hit ? WSS_RESP_OK : WSS_RESP_ERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    // Checks
    auto_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && seq_mode && !adv_on_trigger && count_done |=> idx_q == $past(nidx))
        else $error("auto advance missed");
    trig_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_q && !trig_evt && run && seq_mode |=> $stable(idx_q))
        else $error("advanced without trigger");
    forever_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && seq_mode && !adv_on_trigger && cur_count == 16'h0000 |=> $stable(idx_q))
        else $error("zero count advanced");
    idx_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && seq_mode |-> {1'b0, idx_q} <= last_idx)
        else $error("index beyond length");
    at_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && seq_mode && adv_on_trigger && switch_at_once && trig_evt && !wait_q
        |=> idx_q == $past(nidx))
        else $error("async switch late");
    reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        step |=> rep_q == seg_count_q[idx_q])
        else $error("counter not reloaded");
    edge_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !level_sense && trig_evt |-> trig_in && !trig_prev_q)
        else $error("edge trigger wrong");
    mark_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wa == WSS_MARK_OFS && w_strb_q[0] && w_data_q[WSS_MARK_CLR_BIT]
        |=> mark_q[$past(mk_trace)] == '0)
        else $error("markers not cleared");
    no_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !seq_mode |=> idx_q == 2'h0)
        else $error("sequence ran outside sequence function");
    wrap_c: cover property (@(posedge aclk) disable iff (!aresetn)
        step && idx_q == last_idx);
    trig_c: cover property (@(posedge aclk) disable iff (!aresetn) go_trig_wait);
    sync_c: cover property (@(posedge aclk) disable iff (!aresetn) go_sync && step);
    full_c: cover property (@(posedge aclk) disable iff (!aresetn) sel_push && !fifo_ready);
endmodule : wss_top

/* File: verif/wss_play_model.sv */
`timescale 1ns/100ps
// Stand-in for the playback path and the external trigger source
module wss_play_model (
    input wire logic aclk,
    output logic wave_sel_ready,
    output logic seg_end,
    output logic trig_in
);
    // Idle levels at time zero
    initial begin
        wave_sel_ready = 1'b1;
        seg_end = 1'b0;
        trig_in = 1'b0;
    end
    // Consumer stalls at random, as a busy player would
    always @(posedge aclk) begin
        wave_sel_ready <= ($urandom % 3) != 0;
    end
    // End-point pulses of one cycle, gap cycles apart
    task automatic ends(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge aclk);
            seg_end <= 1'b1;
            @(posedge aclk);
            seg_end <= 1'b0;
        end
    endtask : ends
    // Trigger held high for len cycles: one rising edge per call
    task automatic trig(input int len);
        trig_in <= 1'b1;
        repeat (len) @(posedge aclk);
        trig_in <= 1'b0;
        @(posedge aclk);
    endtask : trig
endmodule : wss_play_model

/* File: verif/test_waveform_segment_sequencer.sv */
`timescale 1ns/100ps
module test_waveform_segment_sequencer;
    import wss_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF; // Byte lanes of the write data
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, trig_in, seg_end;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] wave_sel, u;
    logic wave_sel_valid, wave_sel_ready;
    logic [WSS_NPOINT-1:0] marker_bits [WSS_NTRACE];
    logic [7:0] id [4];
    logic [7:0] exp_q [$]; // Wave ids expected at the FIFO head, oldest first
    logic [3:0] p;
    int num_errors = 0;
    int tests_run = 0;
    localparam logic [1:0] OK = WSS_RESP_OK;

    // Clock, 20 ns period
    always #10 aclk = ~aclk;

    wss_top i_wss_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trig_in(trig_in), .seg_end(seg_end), .wave_sel(wave_sel),
        .wave_sel_valid(wave_sel_valid), .wave_sel_ready(wave_sel_ready),
        .marker_bits(marker_bits));

    wss_play_model i_wss_play_model (.aclk(aclk), .wave_sel_ready(wave_sel_ready),
        .seg_end(seg_end), .trig_in(trig_in));

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        $display("Checks run %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // Scoreboard: every accepted wave id must match the oldest note
    always @(posedge aclk) begin
        if (aresetn && wave_sel_valid && wave_sel_ready) begin
            check("wave_sel", {24'h0, wave_sel},
                exp_q.size() != 0 ? {24'h0, exp_q.pop_front()} : 32'hFFFF_FFFF);
        end
    end

    // One AXI4-Lite transfer; checks the response and, on reads expecting OK, the data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n;
        logic aw, w, ar, hit;
        n = 0;
        hit = 1'b0;
        // Let an edge pass so the last release and this request never share a step
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        while (!hit && n < 50) begin
            @(negedge aclk);
            aw = awready;
            w = wready;
            ar = arready;
            hit = wr ? bvalid : rvalid;
            if (hit) check("resp", {30'h0, wr ? bresp : rresp}, {30'h0, er});
            if (hit && !wr && er == OK) check("rdata", rdata, d);
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (!wr && ar) arvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        if (!hit) begin
            num_errors++;
            final_report();
        end
    endtask : bus

    // Wait, bounded, until every expected wave id has come out
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge aclk);
            n++;
        end
        if (exp_q.size() != 0) begin
            num_errors++;
            final_report();
        end
        repeat (8) @(posedge aclk);
    endtask : drain

    // Entry i: repeat count and wave id
    task automatic ent(input int i, input logic [15:0] c);
        bus(1'b1, WSS_ENTRY_BASE + 8'(4 * i), {c, 8'h00, id[i]}, OK);
    endtask : ent

    // Leave sequence mode for the user wave, then start the sequence
    task automatic go_user();
        exp_q.push_back(u);
        bus(1'b1, WSS_FUNC_OFS, 32'h1, OK);
        drain();
    endtask : go_user
    task automatic go_seq();
        exp_q.push_back(id[0]);
        bus(1'b1, WSS_FUNC_OFS, 32'h2, OK);
    endtask : go_seq

    // Main sequence
    initial begin
        void'($urandom(6484));
        for (int i = 0; i < 4; i++) id[i] = {1'b0, 2'(i), 5'($urandom)};
        u = {2'b10, 6'($urandom)};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, refused accesses
        bus(1'b0, WSS_CTRL_OFS, 32'h20, OK);
        bus(1'b0, WSS_ENTRY_BASE + 8'h04, 32'h0001_0001, OK);
        bus(1'b0, 8'h40, 32'h0, WSS_RESP_ERR);
        bus(1'b1, WSS_ENTRY_BASE + 8'h08, 32'h0001_0000, WSS_RESP_ERR);
        bus(1'b1, WSS_CTRL_OFS, 32'h51, WSS_RESP_ERR);
        bus(1'b1, WSS_SEGSEL_OFS, {24'h0, u}, OK);
        // A write with byte lane 0 off leaves the register alone
        wstrb <= 4'h0;
        bus(1'b1, WSS_SEGSEL_OFS, 32'h5A, OK);
        wstrb <= 4'hF;
        bus(1'b0, WSS_SEGSEL_OFS, {24'h0, u}, OK);
        // Selection only reaches the player while running
        bus(1'b1, WSS_CTRL_OFS, 32'h21, OK);
        go_user();
        // Automatic advance, counts 2,1,1, wrap after the third
        bus(1'b1, WSS_CTRL_OFS, 32'h31, OK);
        ent(0, 16'h2);
        ent(1, 16'h1);
        ent(2, 16'h1);
        go_seq();
        exp_q.push_back(id[1]);
        i_wss_play_model.ends(2, 3);
        exp_q.push_back(id[2]);
        i_wss_play_model.ends(1, 3);
        i_wss_play_model.trig(1);
        exp_q.push_back(id[0]);
        exp_q.push_back(id[1]);
        i_wss_play_model.ends(3, 3);
        drain();
        go_user();
        // Count zero plays the second segment forever
        bus(1'b1, WSS_CTRL_OFS, 32'h21, OK);
        ent(1, 16'h0);
        go_seq();
        exp_q.push_back(id[1]);
        i_wss_play_model.ends(6, 2);
        drain();
        bus(1'b0, WSS_STATUS_OFS, 32'h0000_0001, OK);
        go_user();
        // Advance_on_trigger, synchronous, edge sensitive
        bus(1'b1, WSS_CTRL_OFS, 32'h23, OK);
        ent(1, 16'h1);
        go_seq();
        i_wss_play_model.ends(3, 2);
        drain();
        bus(1'b0, WSS_STATUS_OFS, 32'h0001_0004, OK);
        exp_q.push_back(id[1]);
        i_wss_play_model.trig(3);
        drain();
        i_wss_play_model.ends(1, 2);
        exp_q.push_back(id[0]);
        i_wss_play_model.trig(1);
        drain();
        i_wss_play_model.trig(1);
        repeat (10) @(posedge aclk);
        exp_q.push_back(id[1]);
        i_wss_play_model.ends(1, 2);
        drain();
        go_user();
        // Advance_on_trigger, at once, level sensitive, four segments
        bus(1'b1, WSS_CTRL_OFS, 32'h4F, OK);
        for (int i = 0; i < 4; i++) ent(i, 16'h1);
        go_seq();
        exp_q.push_back(id[1]);
        i_wss_play_model.trig(1);
        drain();
        exp_q.push_back(id[2]);
        exp_q.push_back(id[3]);
        i_wss_play_model.trig(2);
        drain();
        go_user();
        // Set one marker per trace, then clear the trace
        for (int t = 0; t < WSS_NTRACE; t++) begin
            p = 4'($urandom);
            bus(1'b1, WSS_MARK_OFS, 32'h8000_0000 | 32'(t << 16) | 32'(p), OK);
            @(posedge aclk);
            check("marker set", {16'h0, marker_bits[t]}, {16'h0, 16'h0001 << p});
            bus(1'b1, WSS_MARK_OFS, 32'h4000_0000 | 32'(t << 16), OK);
            @(posedge aclk);
            check("marker clear", {16'h0, marker_bits[t]}, 32'h0);
        end
        final_report();
    end
endmodule : test_waveform_segment_sequencer
